// ### common/lbd_pkg.sv
// Package for the link buffer delay register bank.
// Assumes a 32-bit APB slave with byte addresses in the low address bits.
package lbd_pkg;

  // ----------------------------------------
  // Bus layout
  // ----------------------------------------
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;
  localparam logic [APB_AW-1:0] OFS_RX_PATH_DELAY = 8'h4C;
  localparam logic [APB_AW-1:0] OFS_TX_EXT_DELAY = 8'h50;

  // ----------------------------------------
  // Receive path delay fields
  // ----------------------------------------
  localparam int unsigned RX_RESYNC_BIT = 24;
  localparam int unsigned RX_BYTE_DELAY_BIT = 16;
  localparam int unsigned RX_BUF_DEPTH = 6;
  localparam logic RX_RESYNC_RST = 1'h0;

  // ----------------------------------------
  // Transmit extended delay fields
  // ----------------------------------------
  localparam int unsigned TX_PERIOD_LSB = 24;
  localparam int unsigned TX_PERIOD_W = 8;
  localparam int unsigned TX_FRESH_BIT = 23;
  localparam int unsigned TX_RESULT_W = 16;
  localparam logic [TX_PERIOD_W-1:0] TX_PERIOD_RST = 8'h00;
  localparam logic [TX_RESULT_W-1:0] TX_RESULT_RST = 16'h0000;
  localparam logic TX_FRESH_RST = 1'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic byteDelay;
    logic [RX_BUF_DEPTH-1:0] fillLevel;
  } lbd_rx_status_s;

  typedef struct packed {
    logic strobe;
    logic [TX_RESULT_W-1:0] value;
  } lbd_tx_result_s;

  typedef enum logic [1:0] {
    LBD_IDLE = 2'b00,
    LBD_ACCESS = 2'b01,
    LBD_DONE = 2'b10
  } lbd_apb_state_e;

endpackage

// ### rtl/lbd_registers.sv
// Link buffer delay register bank: receive path delay and transmit extended delay.
// Assumes an APB master on clk, status inputs on clk, and a free measurement clock pin.
//
// Operation
// - Resync bit forces receive pointer resync
// - Forced resync may lose in-flight data
// - Rate change resyncs pointers without the bit
// - Byte-alignment delay read at bit 16
// - Receive fill level in low bits
// - Period sets integration window of measurement
// - Fresh flag set on result, read clears
// - Extended result in bits 15 to 0
//
// The implementer's own choice: register access over APB.
module lbd_registers (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lbd_pkg::APB_AW-1:0] paddr,
  input wire logic [lbd_pkg::APB_DW-1:0] pwdata,
  output logic [lbd_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lbd_pkg::lbd_rx_status_s rxStatus,
  input wire logic lineRateChange,
  input wire lbd_pkg::lbd_tx_result_s txResult,
  input wire logic measurement_sample_clock,
  output logic rxResyncForce,
  output logic [lbd_pkg::TX_PERIOD_W-1:0] integrationPeriod,
  output logic windowEnd
);

  logic rxResync_q;
  logic [lbd_pkg::TX_PERIOD_W-1:0] period_q;
  logic [lbd_pkg::TX_PERIOD_W-1:0] windowCount_q;
  logic sampleSync;
  logic sampleLast_q;
  logic sampleEdge;
  logic [lbd_pkg::TX_RESULT_W-1:0] result_q;
  logic fresh_q;
  logic setupPhase;
  logic commit;
  logic hitRx;
  logic hitTx;
  logic txReadClear;
  logic [lbd_pkg::APB_DW-1:0] readWord;
  lbd_pkg::lbd_apb_state_e apbState_q;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign setupPhase = psel && !penable;
  assign commit = psel && penable && pready;
  assign hitRx = (paddr == lbd_pkg::OFS_RX_PATH_DELAY);
  assign hitTx = (paddr == lbd_pkg::OFS_TX_EXT_DELAY);
  assign txReadClear = commit && !pwrite && hitTx;

  always_comb begin
    readWord = '0;
    if (hitRx) begin
      readWord[lbd_pkg::RX_RESYNC_BIT] = rxResync_q;
      readWord[lbd_pkg::RX_BYTE_DELAY_BIT] = rxStatus.byteDelay;
      readWord[lbd_pkg::RX_BUF_DEPTH-1:0] = rxStatus.fillLevel;
    end else if (hitTx) begin
      readWord[lbd_pkg::TX_PERIOD_LSB +: lbd_pkg::TX_PERIOD_W] = period_q;
      readWord[lbd_pkg::TX_FRESH_BIT] = fresh_q;
      readWord[lbd_pkg::TX_RESULT_W-1:0] = result_q;
    end
  end

  // ----------------------------------------
  // APB handshake: one wait-free access cycle
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      apbState_q <= lbd_pkg::LBD_IDLE;
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= '0;
    end else begin
      case (apbState_q)
        lbd_pkg::LBD_IDLE: begin
          if (setupPhase) begin
            apbState_q <= lbd_pkg::LBD_ACCESS;
            pready <= 1'h1;
            pslverr <= !(hitRx || hitTx);
            prdata <= pwrite ? '0 : readWord;
          end
        end
        lbd_pkg::LBD_ACCESS: begin
          apbState_q <= lbd_pkg::LBD_IDLE;
          pready <= 1'h0;
          pslverr <= 1'h0;
          prdata <= '0;
        end
        default: begin
          apbState_q <= lbd_pkg::LBD_IDLE;
          pready <= 1'h0;
          pslverr <= 1'h0;
          prdata <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Writable fields
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxResync_q <= lbd_pkg::RX_RESYNC_RST;
    end else if (commit && pwrite && hitRx) begin
      rxResync_q <= pwdata[lbd_pkg::RX_RESYNC_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_q <= lbd_pkg::TX_PERIOD_RST;
    end else if (commit && pwrite && hitTx) begin
      period_q <= pwdata[lbd_pkg::TX_PERIOD_LSB +: lbd_pkg::TX_PERIOD_W];
    end
  end

  // ----------------------------------------
  // Receive pointer resync request
  // ----------------------------------------
  // Buffered data is not preserved across a forced resync
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxResyncForce <= 1'h0;
    end else begin
      rxResyncForce <= rxResync_q || lineRateChange;
    end
  end

  // ----------------------------------------
  // Integration window on sample clock edges
  // ----------------------------------------
  lbd_sync u_sampleSync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(measurement_sample_clock),
    .syncOut(sampleSync)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sampleLast_q <= 1'h0;
    end else begin
      sampleLast_q <= sampleSync;
    end
  end

  assign sampleEdge = sampleSync && !sampleLast_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      windowCount_q <= '0;
      windowEnd <= 1'h0;
    end else if (period_q == '0) begin
      windowCount_q <= '0;
      windowEnd <= 1'h0;
    end else if (sampleEdge) begin
      if (windowCount_q + 8'h01 >= period_q) begin
        windowCount_q <= '0;
        windowEnd <= 1'h1;
      end else begin
        windowCount_q <= windowCount_q + 8'h01;
        windowEnd <= 1'h0;
      end
    end else begin
      windowEnd <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      integrationPeriod <= lbd_pkg::TX_PERIOD_RST;
    end else begin
      integrationPeriod <= period_q;
    end
  end

  // ----------------------------------------
  // Transmit result and fresh flag
  // ----------------------------------------
  lbd_result_capture u_resultCapture (
    .clk(clk),
    .rst_n(rst_n),
    .resultIn(txResult),
    .readClear(txReadClear),
    .result_q(result_q),
    .fresh_q(fresh_q)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_resyncBitForces;
    @(posedge clk) disable iff (!rst_n)
    rxResync_q |=> rxResyncForce;
  endproperty
  a_resyncBitForces: assert property (p_resyncBitForces)
    else $error("resync bit did not force pointer resync");

  property p_resyncCause;
    @(posedge clk) disable iff (!rst_n)
    rxResyncForce |-> $past(rxResync_q) || $past(lineRateChange);
  endproperty
  a_resyncCause: assert property (p_resyncCause)
    else $error("pointer resync forced without a cause");

  property p_rateChangeResync;
    @(posedge clk) disable iff (!rst_n)
    (lineRateChange && !rxResync_q) |=> rxResyncForce;
  endproperty
  a_rateChangeResync: assert property (p_rateChangeResync)
    else $error("rate change did not resync pointers");

  property p_rxReadWord;
    @(posedge clk) disable iff (!rst_n)
    (setupPhase && !pwrite && hitRx) |=>
      pready && prdata[lbd_pkg::RX_BYTE_DELAY_BIT] == $past(rxStatus.byteDelay)
      && prdata[lbd_pkg::RX_BUF_DEPTH-1:0] == $past(rxStatus.fillLevel);
  endproperty
  a_rxReadWord: assert property (p_rxReadWord)
    else $error("receive delay read data wrong");

  property p_rxReserved;
    @(posedge clk) disable iff (!rst_n)
    (setupPhase && !pwrite && hitRx) |=>
      prdata[31:25] == 7'h00 && prdata[23:17] == 7'h00
      && prdata[15:lbd_pkg::RX_BUF_DEPTH] == '0;
  endproperty
  a_rxReserved: assert property (p_rxReserved)
    else $error("receive reserved bits not zero");

  property p_windowLength;
    @(posedge clk) disable iff (!rst_n)
    windowEnd |-> $past(sampleEdge) && $past(period_q) != '0
      && $past(windowCount_q) + 8'h01 >= $past(period_q);
  endproperty
  a_windowLength: assert property (p_windowLength)
    else $error("integration window ended early");

  property p_freshSetClear;
    @(posedge clk) disable iff (!rst_n)
    txResult.strobe |=> fresh_q ##1 (!fresh_q || !$past(txReadClear) || $past(txResult.strobe));
  endproperty
  a_freshSetClear: assert property (p_freshSetClear)
    else $error("fresh flag not set or cleared properly");

  property p_freshReadClear;
    @(posedge clk) disable iff (!rst_n)
    (txReadClear && !txResult.strobe) |=> !fresh_q;
  endproperty
  a_freshReadClear: assert property (p_freshReadClear)
    else $error("read did not clear fresh flag");

  property p_resultHeld;
    @(posedge clk) disable iff (!rst_n)
    txResult.strobe ##1 !txResult.strobe [*2] |-> result_q == $past(txResult.value, 2);
  endproperty
  a_resultHeld: assert property (p_resultHeld)
    else $error("extended result not stored");

  property p_txReserved;
    @(posedge clk) disable iff (!rst_n)
    (setupPhase && !pwrite && hitTx) |=> prdata[22:16] == 7'h00;
  endproperty
  a_txReserved: assert property (p_txReserved)
    else $error("transmit reserved bits not zero");

  property p_txReadWord;
    @(posedge clk) disable iff (!rst_n)
    (setupPhase && !pwrite && hitTx) |=>
      pready && prdata[lbd_pkg::TX_RESULT_W-1:0] == $past(result_q)
      && prdata[lbd_pkg::TX_FRESH_BIT] == $past(fresh_q)
      && prdata[lbd_pkg::TX_PERIOD_LSB +: lbd_pkg::TX_PERIOD_W] == $past(period_q);
  endproperty
  a_txReadWord: assert property (p_txReadWord)
    else $error("transmit delay read data wrong");

  property p_periodOut;
    @(posedge clk) disable iff (!rst_n)
    (commit && pwrite && hitTx) |=> ##1
      integrationPeriod == $past(pwdata[lbd_pkg::TX_PERIOD_LSB +: lbd_pkg::TX_PERIOD_W], 2);
  endproperty
  a_periodOut: assert property (p_periodOut)
    else $error("integration period not applied");

  property p_resyncWrite;
    @(posedge clk) disable iff (!rst_n)
    (commit && pwrite && hitRx) |=> rxResync_q == $past(pwdata[lbd_pkg::RX_RESYNC_BIT]);
  endproperty
  a_resyncWrite: assert property (p_resyncWrite)
    else $error("resync bit write not stored");

  property p_unmappedError;
    @(posedge clk) disable iff (!rst_n)
    (setupPhase && !(hitRx || hitTx)) |=> pready && pslverr && prdata == '0;
  endproperty
  a_unmappedError: assert property (p_unmappedError)
    else $error("unmapped access not flagged");

  property p_unmappedWrite;
    @(posedge clk) disable iff (!rst_n)
    (commit && pwrite && !(hitRx || hitTx)) |=> $stable(period_q) && $stable(rxResync_q);
  endproperty
  a_unmappedWrite: assert property (p_unmappedWrite)
    else $error("unmapped write changed a register");

endmodule

// ### rtl/lbd_result_capture.sv
// Holds the transmit extended delay result and its fresh flag.
// Assumes result strobes and read-clear pulses arrive on clk.
module lbd_result_capture (
  input wire logic clk,
  input wire logic rst_n,
  input wire lbd_pkg::lbd_tx_result_s resultIn,
  input wire logic readClear,
  output logic [lbd_pkg::TX_RESULT_W-1:0] result_q,
  output logic fresh_q
);

  // ----------------------------------------
  // Result store
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_q <= lbd_pkg::TX_RESULT_RST;
    end else if (resultIn.strobe) begin
      result_q <= resultIn.value;
    end
  end

  // ----------------------------------------
  // Fresh flag, set wins over read clear
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fresh_q <= lbd_pkg::TX_FRESH_RST;
    end else if (resultIn.strobe) begin
      fresh_q <= 1'h1;
    end else if (readClear) begin
      fresh_q <= 1'h0;
    end
  end

endmodule

// ### rtl/lbd_sync.sv
// Two-flop synchroniser for a level arriving from outside the clock domain.
// Assumes the input is slow enough to be sampled as a level.
module lbd_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic asyncIn,
  output logic syncOut
);

  logic meta_q;

  // ----------------------------------------
  // Two stages, first read only by second
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'h0;
      syncOut <= 1'h0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// ### verification/tb_lbd_registers.sv
// Self-checking testbench for the link buffer delay register bank.
// Assumes the design files and lbd_pkg are compiled first; drives every port itself.
module tb_lbd_registers;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals and instance
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  lbd_pkg::lbd_rx_status_s rxStatus = '0;
  logic lineRateChange = 1'b0;
  lbd_pkg::lbd_tx_result_s txResult = '0;
  logic sampleClk = 1'b0;
  logic rxResyncForce;
  logic [7:0] integrationPeriod;
  logic windowEnd;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int winCnt = 0;
  logic [31:0] rd;
  logic er;

  lbd_registers lbd_registers_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxStatus(rxStatus), .lineRateChange(lineRateChange), .txResult(txResult),
    .measurement_sample_clock(sampleClk), .rxResyncForce(rxResyncForce),
    .integrationPeriod(integrationPeriod), .windowEnd(windowEnd)
  );

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (windowEnd === 1'b1) winCnt++;
    if (cyc > 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    wait_clk(2);
    rst_n <= 1'b1;
    apb(1'b0, 8'h4C, 32'h0, rd, er);
    chk(rd, 32'h0000_0000, "rx reset value");
    apb(1'b0, 8'h50, 32'h0, rd, er);
    chk(rd, 32'h0000_0000, "tx reset value");
    $display("Test reset values done");
    rxStatus <= '{byteDelay: 1'b1, fillLevel: 6'h3F};
    apb(1'b0, 8'h4C, 32'h0, rd, er);
    chk(rd, 32'h0001_003F, "rx status full");
    chk({31'h0, er}, 32'h0, "mapped no error");
    apb(1'b1, 8'h4C, 32'hFFFF_FFFF, rd, er);
    wait_clk(2);
    chk({31'h0, rxResyncForce}, 32'h1, "resync force high");
    apb(1'b0, 8'h4C, 32'h0, rd, er);
    chk(rd, 32'h0101_003F, "rx reserved zero");
    apb(1'b1, 8'h4C, 32'h0, rd, er);
    wait_clk(2);
    chk({31'h0, rxResyncForce}, 32'h0, "resync force low");
    $display("Test receive register done");
    lineRateChange <= 1'b1;
    wait_clk(3);
    chk({31'h0, rxResyncForce}, 32'h1, "rate change resync");
    apb(1'b0, 8'h4C, 32'h0, rd, er);
    chk({31'h0, rd[24]}, 32'h0, "rate change leaves bit");
    lineRateChange <= 1'b0;
    wait_clk(3);
    chk({31'h0, rxResyncForce}, 32'h0, "rate change end");
    $display("Test rate change done");
    apb(1'b1, 8'h50, 32'h02FF_FFFF, rd, er);
    wait_clk(2);
    chk({24'h0, integrationPeriod}, 32'h02, "period out");
    apb(1'b0, 8'h50, 32'h0, rd, er);
    chk(rd, 32'h0200_0000, "tx read only ignored");
    @(posedge clk);
    txResult <= {1'b1, 16'hA5C3};
    @(posedge clk);
    txResult <= {1'b0, 16'hA5C3};
    apb(1'b0, 8'h50, 32'h0, rd, er);
    chk(rd, 32'h0280_A5C3, "result and fresh");
    apb(1'b0, 8'h50, 32'h0, rd, er);
    chk(rd, 32'h0200_A5C3, "fresh cleared by read");
    $display("Test transmit register done");
    winCnt = 0;
    repeat (4) begin
      wait_clk(4);
      sampleClk <= 1'b1;
      wait_clk(4);
      sampleClk <= 1'b0;
    end
    wait_clk(6);
    chk(winCnt, 32'd2, "window ends for period 2");
    apb(1'b1, 8'h50, 32'h0000_0000, rd, er);
    winCnt = 0;
    repeat (2) begin
      wait_clk(4);
      sampleClk <= 1'b1;
      wait_clk(4);
      sampleClk <= 1'b0;
    end
    wait_clk(6);
    chk(winCnt, 32'd0, "no window for period 0");
    $display("Test integration window done");
    apb(1'b0, 8'h54, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, 8'h54, 32'hFFFF_FFFF, rd, er);
    chk({31'h0, er}, 32'h1, "unmapped write error");
    apb(1'b0, 8'h4C, 32'h0, rd, er);
    chk(rd, 32'h0001_003F, "unmapped write ignored");
    $display("Test unmapped address done");
    tally_and_finish();
  end
endmodule
